// *** pkg/usbq_pkg.sv ***
// usbq_pkg: offsets, field layouts, reset values and codes for the host queue status block
package usbq_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] OFS_PQ_STAT   = 12'h410; // host_periodic_queue_fifo_status
  localparam logic [11:0] OFS_CH_IRQ    = 12'h414; // host_all_channel_interrupt
  localparam logic [11:0] OFS_CH_EN     = 12'h418; // host_channel_interrupt_enable
  localparam logic [11:0] OFS_PORT_CS   = 12'h440; // host_port_control_status
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h480; // block event status, write one to clear
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h484; // block event mask
  // ==========================================================================
  // reset values
  localparam logic [31:0] RST_PQ_STAT   = 32'h00080200;
  localparam logic [31:0] RST_CH_IRQ    = 32'h00000000;
  localparam logic [31:0] RST_CH_EN     = 32'h00000000;
  localparam logic [31:0] RST_PORT_CS   = 32'h00000000;
  // ==========================================================================
  // queue status fields
  localparam int TOP_CH_LSB    = 27;   // channel number, bits 30:27
  localparam int TOP_TYPE_LSB  = 25;   // request type, bits 26:25
  localparam int TOP_TERM_BIT  = 24;   // terminate marker
  localparam int FREE_ENT_LSB  = 16;   // free queue entries, bits 23:16
  localparam int FREE_WORD_LSB = 0;    // free fifo words, bits 15:0
  localparam logic [1:0] REQ_TOKEN = 2'h0; // in or out token
  localparam logic [1:0] REQ_ZLP   = 2'h1; // zero-length out packet
  localparam logic [1:0] REQ_HALT  = 2'h3; // channel halt request
  localparam int QUEUE_DEPTH   = 8;
  localparam logic [15:0] FIFO_DEPTH_RST = 16'h0200;
  // ==========================================================================
  // port control and status fields
  localparam int PCS_CONN      = 0;
  localparam int PCS_CONN_DET  = 1;
  localparam int PCS_EN        = 2;
  localparam int PCS_EN_CHG    = 3;
  localparam int PCS_RESUME    = 6;
  localparam int PCS_SUSPEND   = 7;
  localparam int PCS_RESET     = 8;
  localparam int PCS_LINE_LSB  = 10;
  localparam int PCS_POWER     = 12;
  localparam int PCS_SPEED_LSB = 17;
  // ==========================================================================
  // block event status bits
  localparam int EV_CH         = 0;  // global channel flag rose
  localparam int EV_PORT       = 1;  // global port flag rose
  localparam int EV_QOVF       = 2;  // push refused, queue full
  localparam int EV_NUM        = 3;
  // ==========================================================================
  // bus data-phase tracking
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b11
  } usbq_bus_e;
endpackage : usbq_pkg

// *** logic/usbq_mem.sv ***
// usbq_mem: small request queue storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module usbq_mem #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  // storage holds data only, so it needs no reset; the top reader gates it by empty
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      // a write to the slot being read passes straight through, so a push into
      // an empty queue is visible at once instead of one cycle late
      rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
    end
  end
endmodule : usbq_mem
`default_nettype wire

// *** logic/usbq_chirq.sv ***
// usbq_chirq: per-channel interrupt summary and global channel flag
`timescale 1ns/1ps
`default_nettype none
module usbq_chirq #(
  parameter int NCH = 8
) (
  input  wire logic [NCH-1:0] pend,
  input  wire logic [NCH-1:0] en,
  output logic      [NCH-1:0] flags,
  output logic                global_flag
);
  logic [NCH-1:0] gated;
  // one summary bit per channel follows that channel's pending state
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign flags[i] = pend[i];
    assign gated[i] = pend[i] & en[i];
  end
  // a disabled channel never reaches the global flag
  assign global_flag = |gated;
endmodule : usbq_chirq
`default_nettype wire

// *** logic/usbq_top.sv ***
// usbq_top: host periodic queue status, channel irq summary and port status registers
// Functional notes
// - top entry channel number in bits 30:27
// - request type codes 00, 01, 11
// - bit 24 marks last entry for channel
// - free queue entries 23:16, at most eight
// - free fifo words 15:0, at most depth
// - channel interrupt sets its summary bit
// - enable gates channel into global flag
// - port flags raise global port flag
// - enable set after reset ends, cleared otherwise
// - enable change sets enable-change flag
// - suspend stops frame starts, limited clears
`timescale 1ns/1ps
`default_nettype none
module usbq_top
  import usbq_pkg::*;
#(
  parameter int          NCH        = 8,
  parameter logic [15:0] FIFO_DEPTH = FIFO_DEPTH_RST
) (
  input  wire logic           CLK,
  input  wire logic           RST,
  input  wire logic           CE,
  // ahb-lite slave
  input  wire logic           HSEL,
  input  wire logic [11:0]    HADDR,
  input  wire logic [1:0]     HTRANS,
  input  wire logic           HWRITE,
  input  wire logic [2:0]     HSIZE,
  input  wire logic [31:0]    HWDATA,
  input  wire logic           HREADY,
  output logic      [31:0]    HRDATA,
  output logic                HREADYOUT,
  output logic                HRESP,
  // periodic request queue from the scheduler
  input  wire logic           PQ_PUSH,
  input  wire logic [3:0]     PQ_PUSH_CH,
  input  wire logic [1:0]     PQ_PUSH_TYPE,
  input  wire logic           PQ_PUSH_TERM,
  input  wire logic           PQ_POP,
  output logic                PQ_FULL,
  // periodic fifo word accounting
  input  wire logic           FIFO_WORD_IN,
  input  wire logic           FIFO_WORD_OUT,
  // channels and port line
  input  wire logic [NCH-1:0] CH_IRQ_PEND,
  input  wire logic           CONNECTED,
  input  wire logic           REMOTE_WAKE,
  input  wire logic [1:0]     LINE_STATE,
  input  wire logic [1:0]     ATTACHED_SPEED,
  output logic                PORT_RESET_DRIVE,
  output logic                PORT_RESUME_DRIVE,
  output logic                PORT_POWER,
  output logic                SOF_ENABLE,
  output logic                GLOBAL_CHANNEL_IRQ,
  output logic                GLOBAL_PORT_IRQ,
  output logic                IRQ
);
  localparam int QAW = $clog2(QUEUE_DEPTH);
  localparam int QCW = QAW + 1;

  // ==========================================================================
  // bus slave state
  usbq_bus_e        bus_reg,   bus_next;
  logic [11:0]      addr_reg,  addr_next;
  logic [31:0]      rdata_reg, rdata_next;
  // queue state
  logic [QAW-1:0]   wptr_reg,  wptr_next;
  logic [QAW-1:0]   rptr_reg,  rptr_next;
  logic [QCW-1:0]   qcnt_reg,  qcnt_next;
  logic [15:0]      fwords_reg, fwords_next;
  // port state
  logic             conn_prev_reg, pwr_reg, rsig_reg, rsum_reg, susp_reg;
  logic             ena_reg, echg_reg, cdet_reg;
  logic             pwr_next, rsig_next, rsum_next, susp_next, ena_next, echg_next, cdet_next;
  // enables and events
  logic [NCH-1:0]   chen_reg,  chen_next;
  logic [EV_NUM-1:0] istat_reg, istat_next;
  logic [EV_NUM-1:0] imask_reg, imask_next;
  logic             gch_prev_reg, gpt_prev_reg;

  logic [6:0]       top_raw;
  logic [NCH-1:0]   ch_flags;
  logic             gch, gpt;
  logic             addr_take, wr_now;
  logic             push_ok, pop_ok, push_refused;
  logic [31:0]      wd;

  // ==========================================================================
  // queue storage and channel summary
  usbq_mem #(.WIDTH(7), .DEPTH(QUEUE_DEPTH), .AW(QAW)) u_mem (
    .clk   (CLK),
    .ce    (CE),
    .we    (push_ok),
    .waddr (wptr_reg),
    .wdata ({PQ_PUSH_CH, PQ_PUSH_TYPE, PQ_PUSH_TERM}),
    .raddr (rptr_next),
    .rdata (top_raw)
  );

  usbq_chirq #(.NCH(NCH)) u_chirq (
    .pend        (CH_IRQ_PEND),
    .en          (chen_reg),
    .flags       (ch_flags),
    .global_flag (gch)
  );

  // ==========================================================================
  // bus decode: zero wait state, stalled only while the clock enable is low
  assign HREADYOUT = CE;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_reg;
  assign addr_take = HSEL & HTRANS[1] & HREADY;
  assign wr_now    = (bus_reg == BUS_WRITE);
  // narrow writes still land as whole words, software must not issue them
  assign wd        = HWDATA;

  // ==========================================================================
  // queue and fifo accounting
  assign PQ_FULL      = (qcnt_reg == QCW'(QUEUE_DEPTH));
  assign push_ok      = PQ_PUSH & ~PQ_FULL;
  assign pop_ok       = PQ_POP & (qcnt_reg != '0);
  assign push_refused = PQ_PUSH & PQ_FULL;

  // next queue pointers, entry count and free fifo words
  always_comb begin
    wptr_next   = push_ok ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next   = pop_ok ? rptr_reg + 1'b1 : rptr_reg;
    qcnt_next   = qcnt_reg;
    fwords_next = fwords_reg;
    if (push_ok && !pop_ok) begin
      qcnt_next = qcnt_reg + 1'b1;
    end else if (pop_ok && !push_ok) begin
      qcnt_next = qcnt_reg - 1'b1;
    end
    // saturate so the count never leaves 0..depth
    if (FIFO_WORD_IN && !FIFO_WORD_OUT && fwords_reg != 16'h0000) begin
      fwords_next = fwords_reg - 16'h0001;
    end else if (FIFO_WORD_OUT && !FIFO_WORD_IN && fwords_reg != FIFO_DEPTH) begin
      fwords_next = fwords_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // port control and status next values
  always_comb begin
    logic sw_wr;
    logic disc;
    logic rst_end;
    sw_wr     = wr_now & (addr_reg == OFS_PORT_CS);
    disc      = conn_prev_reg & ~CONNECTED;
    pwr_next  = sw_wr ? wd[PCS_POWER]  : pwr_reg;
    rsig_next = sw_wr ? wd[PCS_RESET]  : rsig_reg;
    rsum_next = sw_wr ? wd[PCS_RESUME] : rsum_reg;
    rst_end   = rsig_reg & ~rsig_next;
    // suspend is set by software only; the listed conditions take it down
    susp_next = susp_reg | (sw_wr & wd[PCS_SUSPEND]);
    if ((rsig_next & ~rsig_reg) | (rsum_next & ~rsum_reg) | REMOTE_WAKE | disc) begin
      susp_next = 1'b0;
    end
    // enable: hardware sets at end of reset, never software; set wins the clear
    ena_next = ena_reg;
    if (disc | (sw_wr & wd[PCS_EN])) begin
      ena_next = 1'b0;
    end
    if (rst_end & CONNECTED) begin
      ena_next = 1'b1;
    end
    echg_next = (echg_reg & ~(sw_wr & wd[PCS_EN_CHG])) | (ena_next ^ ena_reg);
    cdet_next = (cdet_reg & ~(sw_wr & wd[PCS_CONN_DET])) | (CONNECTED & ~conn_prev_reg);
  end

  // ==========================================================================
  // global flags and block interrupt
  assign gpt                = cdet_reg | echg_reg | rsig_reg;
  assign GLOBAL_CHANNEL_IRQ = gch;
  assign GLOBAL_PORT_IRQ    = gpt;
  assign IRQ                = |(istat_reg & imask_reg);
  assign PORT_RESET_DRIVE   = rsig_reg;
  assign PORT_RESUME_DRIVE  = rsum_reg;
  assign PORT_POWER         = pwr_reg;
  // no frame starts while suspended or disabled
  assign SOF_ENABLE         = ena_reg & ~susp_reg;

  // enables, event status and mask next values
  always_comb begin
    logic [EV_NUM-1:0] ev;
    ev           = '0;
    ev[EV_CH]    = gch & ~gch_prev_reg;
    ev[EV_PORT]  = gpt & ~gpt_prev_reg;
    ev[EV_QOVF]  = push_refused;
    chen_next    = chen_reg;
    imask_next   = imask_reg;
    istat_next   = istat_reg;
    if (wr_now && addr_reg == OFS_CH_EN) begin
      chen_next = wd[NCH-1:0];
    end
    if (wr_now && addr_reg == OFS_IRQ_MASK) begin
      imask_next = wd[EV_NUM-1:0];
    end
    if (wr_now && addr_reg == OFS_IRQ_STAT) begin
      istat_next = istat_reg & ~wd[EV_NUM-1:0];
    end
    // an event in the clearing cycle survives
    istat_next = istat_next | ev;
  end

  // ==========================================================================
  // bus phase tracking and read mux; read data taken from next values so a
  // read right behind a write already sees the written value
  always_comb begin
    logic [31:0] pq;
    logic [31:0] pcs;
    pq  = '0;
    pcs = '0;
    if (qcnt_next != '0) begin
      pq[TOP_CH_LSB +: 4]   = top_raw[6:3];
      pq[TOP_TYPE_LSB +: 2] = top_raw[2:1];
      pq[TOP_TERM_BIT]      = top_raw[0];
    end
    pq[FREE_ENT_LSB +: 8]   = 8'(QUEUE_DEPTH) - 8'(qcnt_next);
    pq[FREE_WORD_LSB +: 16] = fwords_next;
    pcs[PCS_CONN]           = CONNECTED;
    pcs[PCS_CONN_DET]       = cdet_next;
    pcs[PCS_EN]             = ena_next;
    pcs[PCS_EN_CHG]         = echg_next;
    pcs[PCS_RESUME]         = rsum_next;
    pcs[PCS_SUSPEND]        = susp_next;
    pcs[PCS_RESET]          = rsig_next;
    pcs[PCS_LINE_LSB +: 2]  = LINE_STATE;
    pcs[PCS_POWER]          = pwr_next;
    pcs[PCS_SPEED_LSB +: 2] = ATTACHED_SPEED;
    bus_next   = BUS_IDLE;
    addr_next  = addr_reg;
    rdata_next = rdata_reg;
    if (addr_take) begin
      addr_next  = HADDR;
      bus_next   = HWRITE ? BUS_WRITE : BUS_READ;
      rdata_next = 32'h00000000;
      if (!HWRITE) begin
        if (HADDR == OFS_PQ_STAT) begin
          rdata_next = pq;
        end else if (HADDR == OFS_CH_IRQ) begin
          rdata_next[NCH-1:0] = ch_flags;
        end else if (HADDR == OFS_CH_EN) begin
          rdata_next[NCH-1:0] = chen_next;
        end else if (HADDR == OFS_PORT_CS) begin
          rdata_next = pcs;
        end else if (HADDR == OFS_IRQ_STAT) begin
          rdata_next[EV_NUM-1:0] = istat_next;
        end else if (HADDR == OFS_IRQ_MASK) begin
          rdata_next[EV_NUM-1:0] = imask_next;
        end
      end
    end
  end

  // ==========================================================================
  // all state registers; clock enable low freezes everything
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_reg       <= BUS_IDLE;
      addr_reg      <= 12'h000;
      rdata_reg     <= 32'h00000000;
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      qcnt_reg      <= '0;
      fwords_reg    <= FIFO_DEPTH;
      conn_prev_reg <= 1'b0;
      pwr_reg       <= 1'b0;
      rsig_reg      <= 1'b0;
      rsum_reg      <= 1'b0;
      susp_reg      <= 1'b0;
      ena_reg       <= 1'b0;
      echg_reg      <= 1'b0;
      cdet_reg      <= 1'b0;
      chen_reg      <= '0;
      istat_reg     <= '0;
      imask_reg     <= '0;
      gch_prev_reg  <= 1'b0;
      gpt_prev_reg  <= 1'b0;
    end else if (CE) begin
      bus_reg       <= bus_next;
      addr_reg      <= addr_next;
      rdata_reg     <= rdata_next;
      wptr_reg      <= wptr_next;
      rptr_reg      <= rptr_next;
      qcnt_reg      <= qcnt_next;
      fwords_reg    <= fwords_next;
      conn_prev_reg <= CONNECTED;
      pwr_reg       <= pwr_next;
      rsig_reg      <= rsig_next;
      rsum_reg      <= rsum_next;
      susp_reg      <= susp_next;
      ena_reg       <= ena_next;
      echg_reg      <= echg_next;
      cdet_reg      <= cdet_next;
      chen_reg      <= chen_next;
      istat_reg     <= istat_next;
      imask_reg     <= imask_next;
      gch_prev_reg  <= gch;
      gpt_prev_reg  <= gpt;
    end
  end
endmodule : usbq_top
`default_nettype wire

// *** tb/usbq_chk.sv ***
// usbq_chk: port-level assertions for the host queue status block
`timescale 1ns/1ps
`default_nettype none
module usbq_chk
  import usbq_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic           CLK,
  input wire logic           RST,
  input wire logic           CE,
  input wire logic           HSEL,
  input wire logic [11:0]    HADDR,
  input wire logic [1:0]     HTRANS,
  input wire logic           HWRITE,
  input wire logic           HREADY,
  input wire logic [31:0]    HRDATA,
  input wire logic           PQ_PUSH,
  input wire logic           PQ_POP,
  input wire logic           PQ_FULL,
  input wire logic [NCH-1:0] CH_IRQ_PEND,
  input wire logic           CONNECTED,
  input wire logic           PORT_RESET_DRIVE,
  input wire logic           SOF_ENABLE,
  input wire logic           GLOBAL_CHANNEL_IRQ,
  input wire logic           GLOBAL_PORT_IRQ
);
  // ==================================================
  // shadow entry count; refused pushes and empty pops leave it alone
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (CE && PQ_PUSH && cnt_reg != 4'h8) cnt_next = cnt_next + 4'h1;
    if (CE && PQ_POP && cnt_reg != 4'h0) cnt_next = cnt_next - 4'h1;
  end
  always_ff @(posedge CLK) begin
    if (RST) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_next;
  end
  // ==================================================
  // assertions, all in the one clock domain
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_queue_full_count: assert property (PQ_FULL == (cnt_reg == 4'h8))
    else $error("queue full flag disagrees with entry count");
  a_chan_gate: assert property (GLOBAL_CHANNEL_IRQ |-> CH_IRQ_PEND != '0)
    else $error("channel flag without any pending channel");
  a_chan_steady: assert property (
    $stable(CH_IRQ_PEND) && $past(HTRANS) == 2'b00 && $past(HTRANS, 2) == 2'b00
    |-> $stable(GLOBAL_CHANNEL_IRQ)) else $error("channel flag moved without cause");
  a_reset_port_irq: assert property (PORT_RESET_DRIVE |-> GLOBAL_PORT_IRQ)
    else $error("port reset without port flag");
  a_conn_port_irq: assert property ($rose(CONNECTED) && CE |-> ##[1:2] GLOBAL_PORT_IRQ)
    else $error("attach did not raise port flag");
  a_disc_disable: assert property ($fell(CONNECTED) && CE |-> ##2 !SOF_ENABLE)
    else $error("port still enabled after detach");
  a_reset_end_chg: assert property (
    $fell(PORT_RESET_DRIVE) && $past(CONNECTED) && $past(CE) && !$past(SOF_ENABLE)
    |-> GLOBAL_PORT_IRQ) else $error("reset end gave no enable change");
  a_summary_read: assert property (
    HSEL && HTRANS[1] && HREADY && CE && !HWRITE && HADDR == OFS_CH_IRQ
    && $stable(CH_IRQ_PEND) |=> HRDATA[NCH-1:0] == $past(CH_IRQ_PEND)
    && (HRDATA >> NCH) == 32'h00000000) else $error("channel summary read wrong");
  c_full_push: cover property (PQ_FULL && PQ_PUSH);
  c_reset_end: cover property ($fell(PORT_RESET_DRIVE));
  c_chan_irq: cover property ($rose(GLOBAL_CHANNEL_IRQ));
endmodule : usbq_chk
`default_nettype wire

// *** tb/usbq_dev.sv ***
// usbq_dev: attached full-speed device seen from the host port
`timescale 1ns/1ps
`default_nettype none
module usbq_dev (
  input  wire logic       attach,
  input  wire logic       wake,
  output logic            connected,
  output logic      [1:0] line_state,
  output logic      [1:0] speed,
  output logic            remote_wake
);
  // detached lines fall to the host pull-downs, so no stale level lingers
  assign connected   = attach;
  assign line_state  = attach ? 2'b01 : 2'b00;
  assign speed       = attach ? 2'b01 : 2'b00;
  assign remote_wake = attach & wake;
endmodule : usbq_dev
`default_nettype wire

// *** tb/test_usb_host_queue_status_and_channel_irq.sv ***
// testbench for the host queue status and channel irq block
`timescale 1ns/1ps
`default_nettype none
module test_usb_host_queue_status_and_channel_irq import usbq_pkg::*;;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e;} usbq_row_s;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00, push_type = 2'b00;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h00000000, hrdata, rd;
  logic        hreadyout, hresp, push = 1'b0, pop = 1'b0, term = 1'b0, full;
  logic [3:0]  push_ch = 4'h0;
  logic        w_in = 1'b0, w_out = 1'b0, attach = 1'b0, wake = 1'b0;
  logic [7:0]  pend = 8'h00;
  logic        conn, rwake, rst_drv, resm, pwr, sof, gch, gport, irq;
  logic [1:0]  lst, spd;
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  // plain register accesses: write first when wr is set, then read back
  usbq_row_s rows [8] = '{
    '{1'b0, OFS_PQ_STAT, 32'h00000000, RST_PQ_STAT},
    '{1'b0, OFS_CH_IRQ, 32'h00000000, RST_CH_IRQ},
    '{1'b0, OFS_PORT_CS, 32'h00000000, RST_PORT_CS},
    '{1'b1, OFS_CH_EN, 32'h0000005A, 32'h0000005A},
    '{1'b1, OFS_PQ_STAT, 32'hFFFFFFFF, RST_PQ_STAT},
    '{1'b1, OFS_CH_IRQ, 32'h000000FF, RST_CH_IRQ},
    '{1'b1, 12'h47C, 32'h00001234, 32'h00000000},
    '{1'b1, OFS_IRQ_MASK, 32'h00000000, 32'h00000000}};
  usbq_top dut_u (.CLK(clk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PQ_PUSH(push), .PQ_PUSH_CH(push_ch),
    .PQ_PUSH_TYPE(push_type), .PQ_PUSH_TERM(term), .PQ_POP(pop), .PQ_FULL(full),
    .FIFO_WORD_IN(w_in), .FIFO_WORD_OUT(w_out), .CH_IRQ_PEND(pend), .CONNECTED(conn),
    .REMOTE_WAKE(rwake), .LINE_STATE(lst), .ATTACHED_SPEED(spd), .PORT_RESET_DRIVE(rst_drv),
    .PORT_RESUME_DRIVE(resm), .PORT_POWER(pwr), .SOF_ENABLE(sof), .GLOBAL_CHANNEL_IRQ(gch),
    .GLOBAL_PORT_IRQ(gport), .IRQ(irq));
  usbq_dev dev_u (.attach(attach), .wake(wake), .connected(conn), .line_state(lst),
    .speed(spd), .remote_wake(rwake));
  // ==================================================
  // helpers
  always #50 clk = ~clk;
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // a hung handshake must not stall the run forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask : wait_rdy
  // one word transfer; address phase held until ready, read data taken at data-phase end
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic settle;
    @(negedge clk);
  endtask : settle
  function automatic logic [7:0] ent(input int i);
    logic [1:0] t;
    t = (i % 3 == 0) ? REQ_TOKEN : (i % 3 == 1) ? REQ_ZLP : REQ_HALT;
    return {1'b0, 4'(i + 1), t, ~i[0]};
  endfunction : ent
  // back-to-back pushes of entries lo..hi
  task automatic push_rng(input int lo, input int hi);
    logic [7:0] e;
    @(posedge clk);
    for (int i = lo; i <= hi; i++) begin
      e = ent(i);
      {push_ch, push_type, term} <= e[6:0];
      push <= 1'b1;
      @(posedge clk);
    end
    push <= 1'b0;
  endtask : push_rng
  // ==================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h00000000);
      chk(rd, rows[i].e, "register row");
      chk(hresp, 1'b0, "okay response");
    end
    // queue: first entry, fill past full, then pops with fifo word traffic
    push_rng(0, 0);
    bus(1'b0, OFS_PQ_STAT, 32'h00000000);
    chk(rd, {ent(0), 8'h07, FIFO_DEPTH_RST}, "first entry");
    push_rng(1, 9);
    chk(full, 1'b1, "queue full");
    bus(1'b0, OFS_PQ_STAT, 32'h00000000);
    chk(rd, {ent(0), 8'h00, FIFO_DEPTH_RST}, "full status");
    bus(1'b1, OFS_IRQ_MASK, 32'h00000004);
    settle();
    chk(irq, 1'b1, "refused push irq");
    bus(1'b1, OFS_IRQ_STAT, 32'h00000004);
    settle();
    chk(irq, 1'b0, "irq cleared");
    @(posedge clk);
    pop <= 1'b1;
    w_in <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    w_out <= 1'b1;
    @(posedge clk);
    w_out <= 1'b0;
    @(posedge clk);
    w_in <= 1'b0;
    bus(1'b0, OFS_PQ_STAT, 32'h00000000);
    chk(rd, {ent(1), 8'h01, 16'h01FE}, "after pop");
    @(posedge clk);
    pop <= 1'b1;
    w_out <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    repeat (2) @(posedge clk);
    w_out <= 1'b0;
    bus(1'b0, OFS_PQ_STAT, 32'h00000000);
    chk(rd, {ent(2), 8'h02, FIFO_DEPTH_RST}, "halt entry, fifo capped");
    // channel summary and enable gating, enables hold 0x5A here
    @(posedge clk);
    pend <= 8'hA5;
    bus(1'b0, OFS_CH_IRQ, 32'h00000000);
    chk(rd, 32'h000000A5, "channel summary");
    chk(gch, 1'b0, "masked channels");
    @(posedge clk);
    pend <= 8'h02;
    settle();
    chk(gch, 1'b1, "enabled channel");
    bus(1'b1, OFS_CH_EN, 32'h00000000);
    settle();
    chk(gch, 1'b0, "enable removed");
    // port: attach, reset, suspend, wakeup, detach
    @(posedge clk);
    attach <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, OFS_PORT_CS, 32'h00000000);
    chk(rd, 32'h00020403, "attach");
    chk(gport, 1'b1, "attach port flag");
    bus(1'b1, OFS_PORT_CS, 32'h00001042);
    bus(1'b0, OFS_PORT_CS, 32'h00000000);
    chk(rd, 32'h00021441, "detect cleared");
    chk({pwr, resm}, 2'b11, "power and resume pins");
    bus(1'b1, OFS_PORT_CS, 32'h00000100);
    settle();
    chk({rst_drv, gport}, 2'b11, "port reset flag");
    bus(1'b1, OFS_PORT_CS, 32'h00000000);
    bus(1'b0, OFS_PORT_CS, 32'h00000000);
    chk(rd, 32'h0002040D, "reset end enables");
    bus(1'b1, OFS_PORT_CS, 32'h00000008);
    bus(1'b0, OFS_PORT_CS, 32'h00000000);
    chk(rd, 32'h00020405, "change cleared");
    chk(sof, 1'b1, "frames run");
    bus(1'b1, OFS_PORT_CS, 32'h00000080);
    settle();
    chk(sof, 1'b0, "suspend stops frames");
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(posedge clk);
    settle();
    chk(sof, 1'b1, "wakeup ends suspend");
    @(posedge clk);
    attach <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b0, OFS_PORT_CS, 32'h00000000);
    chk(rd, 32'h00000008, "detach");
    // clock enable low freezes queue and fifo state and stalls the bus
    @(posedge clk);
    ce <= 1'b0;
    pop <= 1'b1;
    w_in <= 1'b1;
    repeat (2) @(posedge clk);
    chk(hreadyout, 1'b0, "stalled while frozen");
    ce <= 1'b1;
    pop <= 1'b0;
    w_in <= 1'b0;
    bus(1'b0, OFS_PQ_STAT, 32'h00000000);
    chk(rd, {ent(2), 8'h02, FIFO_DEPTH_RST}, "frozen queue");
    // second reset mid-run restores the queue status
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_PQ_STAT, 32'h00000000);
    chk(rd, RST_PQ_STAT, "status after reset");
    chk(full, 1'b0, "not full after reset");
    summarize();
  end
endmodule : test_usb_host_queue_status_and_channel_irq
bind usbq_top usbq_chk #(.NCH(NCH)) chk_u (.CLK(CLK), .RST(RST), .CE(CE), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .PQ_PUSH(PQ_PUSH), .PQ_POP(PQ_POP), .PQ_FULL(PQ_FULL), .CH_IRQ_PEND(CH_IRQ_PEND),
  .CONNECTED(CONNECTED), .PORT_RESET_DRIVE(PORT_RESET_DRIVE), .SOF_ENABLE(SOF_ENABLE),
  .GLOBAL_CHANNEL_IRQ(GLOBAL_CHANNEL_IRQ), .GLOBAL_PORT_IRQ(GLOBAL_PORT_IRQ));
`default_nettype wire
